// ### common/adc_seq_pkg.sv
// Package: constants, types and carriers for the ADC sample sequencer
package adc_seq_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_SEQ    = 4;
  localparam int unsigned MAX_STEPS  = 8;
  localparam int unsigned STEP_W     = 3;
  localparam int unsigned CNT_W      = 4;
  localparam int unsigned SAMPLE_W   = 10;
  localparam int unsigned CHAN_W     = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned ACC_W      = SAMPLE_W + 6;

  // Steps available to each sequence
  localparam logic [CNT_W-1:0] SEQ0_STEPS = 4'h8;
  localparam logic [CNT_W-1:0] SEQ1_STEPS = 4'h4;
  localparam logic [CNT_W-1:0] SEQ2_STEPS = 4'h4;
  localparam logic [CNT_W-1:0] SEQ3_STEPS = 4'h1;

  // ****************************************************************
  // Channel selection: six external inputs and the temperature sensor
  // ****************************************************************
  localparam logic [CHAN_W-1:0] CHAN_LAST_EXT = 3'h5;
  localparam logic [CHAN_W-1:0] CHAN_TEMP     = 3'h6;

  // ****************************************************************
  // Trigger sources and averaging codes
  // ****************************************************************
  typedef enum logic [1:0] {
    TRIG_PROCESSOR,
    TRIG_EXTERNAL,
    TRIG_TIMER,
    TRIG_ALWAYS
  } trig_src_e;

  // Averaging factor is log2 of the ratio; zero disables averaging
  localparam logic [2:0] AVG_OFF = 3'h0;
  localparam logic [2:0] AVG_MAX = 3'h6;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              en;
    trig_src_e         trig;
    logic [1:0]        prio;
    logic [CNT_W-1:0]  nsteps;
  } seq_cfg_s;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              irq_en;
  } step_cfg_s;

  typedef struct packed {
    logic                valid;
    logic [1:0]          seq;
    logic [SAMPLE_W-1:0] data;
  } result_s;

endpackage

// ### design/adc_sample_sequencer.sv
// Design: four-sequence ADC sample sequencer with averager and FIFOs
`timescale 1ns/100ps

// Function
// - Four sequencers holding eight, four, four and one step.
// - Six analog inputs plus the temperature sensor, chosen per step.
// - Each step selects its own channel independently, any order or repeat.
// - Highest priority pending sequence goes first; others may starve.
// - Averager offers 2x to 64x over consecutive same-input readings.
// - Averaging factor zero delivers each conversion unaveraged.
// - Averaging is global and each FIFO entry is one averaged reading.
// - Throughput drops by the averaging ratio.
// - Clearing one sequence's interrupt leaves other flags untouched.
// - Enabling an interrupt first discards its pending flag.
// - Disabling an interrupt stops that sequence driving the output.
// - Raw and masked flags exposed; masked is raw AND enable.
// - Software trigger starts a sequence only if its source is processor.
// - Two-bit priority, zero highest; software keeps values unique.
// - Overflow flag set when a trigger arrives before FIFO was read, except for always-trigger sequences.
// - Always-trigger sequence re-runs whenever nothing higher is pending.
module adc_sample_sequencer (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // Configuration
  input  wire adc_seq_pkg::seq_cfg_s [3:0]  seq_cfg_i,
  input  wire adc_seq_pkg::step_cfg_s [7:0] step_cfg_i [4],
  input  wire logic [2:0]                   averaging_factor_i,
  // Triggers
  input  wire logic [3:0]                   proc_trig_i,
  input  wire logic                         ext_trig_i,
  input  wire logic                         timer_trig_i,
  // Interrupt control, one-cycle pulses per sequence, plus level masked status select
  input  wire logic [3:0]                   int_enable_i,
  input  wire logic [3:0]                   int_disable_i,
  input  wire logic [3:0]                   int_clear_i,
  input  wire logic                         masked_status_select_i,
  input  wire logic [3:0]                   ovf_clear_i,
  // FIFO readout
  input  wire logic [3:0]                   fifo_pop_i,
  // Converter core
  output logic                              conv_start_o,
  output logic [2:0]                        conv_chan_o,
  input  wire logic                         conv_done_i,
  input  wire logic [9:0]                   conv_data_i,
  // Status
  output logic [3:0]                        int_status_o,
  output logic                              int_o,
  output logic [3:0]                        overflow_o,
  output logic [3:0]                        fifo_empty_o,
  output adc_seq_pkg::result_s [3:0]        fifo_head_o,
  output logic [3:0]                        busy_o
);

  // ****************************************************************
  // Local types and state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT
  } state_e;
  localparam logic [adc_seq_pkg::CNT_W-1:0] SEQ_STEPS [4] = '{
    adc_seq_pkg::SEQ0_STEPS, adc_seq_pkg::SEQ1_STEPS,
    adc_seq_pkg::SEQ2_STEPS, adc_seq_pkg::SEQ3_STEPS};
  state_e                                state_r;
  logic [3:0]                            pend_r;
  logic [1:0]                            cur_seq_r;
  logic [adc_seq_pkg::STEP_W-1:0]        step_r;
  logic [6:0]                            avg_cnt_r;
  logic [adc_seq_pkg::ACC_W-1:0]         acc_r;
  logic [3:0]                            raw_int_r;
  logic [3:0]                            int_en_r;
  logic [3:0]                            ovf_r;
  logic [3:0]                            busy_r;
  // FIFO storage per sequence
  logic [adc_seq_pkg::SAMPLE_W-1:0] mem_r [4][adc_seq_pkg::FIFO_DEPTH];
  logic [2:0]                            wptr_r [4];
  logic [2:0]                            rptr_r [4];
  logic [adc_seq_pkg::CNT_W-1:0]         cnt_r  [4];

  // ****************************************************************
  // Trigger qualification
  // ****************************************************************
  logic [3:0] trig;
  logic [3:0] sel;
  logic       any_sel;
  logic [1:0] sel_idx;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (seq_cfg_i[i].trig)
        adc_seq_pkg::TRIG_PROCESSOR: trig[i] = proc_trig_i[i];
        adc_seq_pkg::TRIG_EXTERNAL:  trig[i] = ext_trig_i;
        adc_seq_pkg::TRIG_TIMER:     trig[i] = timer_trig_i;
        adc_seq_pkg::TRIG_ALWAYS:    trig[i] = 1'b1;
        default:                     trig[i] = 1'b0;
      endcase
      trig[i] = trig[i] & seq_cfg_i[i].en;
    end
  end

  always_comb begin
    any_sel = 1'b0;
    sel_idx = 2'h0;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 4; i++) begin
        if (!any_sel && pend_r[i] && seq_cfg_i[i].prio == p[1:0]) begin
          any_sel = 1'b1;
          sel_idx = i[1:0];
        end
      end
    end
    sel = any_sel ? 4'(4'h1 << sel_idx) : 4'h0;
  end

  // ****************************************************************
  // Conversion sequencing and averaging
  // ****************************************************************
  logic [6:0]  avg_target;
  logic        avg_last;
  logic        step_last;
  logic [adc_seq_pkg::ACC_W-1:0] acc_sum;
  logic [adc_seq_pkg::SAMPLE_W-1:0] avg_val;
  logic        push;
  logic [adc_seq_pkg::CNT_W-1:0] nsteps;
  adc_seq_pkg::step_cfg_s cur_step;
  logic [2:0]  avg_shift;
  always_comb begin
    // Factors above the largest supported are clamped to it
    avg_shift  = (averaging_factor_i > adc_seq_pkg::AVG_MAX) ?
                 adc_seq_pkg::AVG_MAX : averaging_factor_i;
    avg_target = 7'(7'h1 << avg_shift);
    nsteps = seq_cfg_i[cur_seq_r].nsteps;
    if (nsteps > SEQ_STEPS[cur_seq_r] || nsteps == '0) begin
      nsteps = SEQ_STEPS[cur_seq_r];
    end
    cur_step  = step_cfg_i[cur_seq_r][step_r];
    avg_last  = (avg_cnt_r + 7'h1) == avg_target;
    step_last = ({1'b0, step_r} + 4'h1) == nsteps;
    acc_sum   = acc_r + adc_seq_pkg::ACC_W'(conv_data_i);
    // factor zero gives shift of zero
    avg_val   = adc_seq_pkg::SAMPLE_W'(acc_sum >> avg_shift);
    push      = state_r == ST_WAIT && conv_done_i && avg_last;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= ST_IDLE;
      cur_seq_r    <= 2'h0;
      step_r       <= '0;
      avg_cnt_r    <= 7'h0;
      acc_r        <= '0;
      conv_start_o <= 1'b0;
      conv_chan_o  <= 3'h0;
    end else begin
      conv_start_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (any_sel) begin
            cur_seq_r <= sel_idx;
            step_r    <= '0;
            avg_cnt_r <= 7'h0;
            acc_r     <= '0;
            state_r   <= ST_START;
          end
        end
        ST_START: begin
          conv_chan_o  <= cur_step.chan;
          conv_start_o <= 1'b1;
          state_r      <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done_i) begin
            if (!avg_last) begin
              acc_r     <= acc_sum;
              avg_cnt_r <= avg_cnt_r + 7'h1;
              state_r   <= ST_START;
            end else begin
              acc_r     <= '0;
              avg_cnt_r <= 7'h0;
              if (step_last) begin
                state_r <= ST_IDLE;
              end else begin
                step_r  <= step_r + 3'h1;
                state_r <= ST_START;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pending and busy flags; a trigger at dispatch is absorbed by that run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 4'h0;
      busy_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (state_r == ST_IDLE && sel[i]) begin
          busy_r[i] <= 1'b1;
        end else if (push && step_last && cur_seq_r == i[1:0]) begin
          busy_r[i] <= 1'b0;
        end
        if (trig[i] && !(busy_r[i] || (state_r == ST_IDLE && sel[i]))) begin
          pend_r[i] <= 1'b1;
        end else if (state_r == ST_IDLE && sel[i]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Result FIFOs
  // ****************************************************************
  // Pushes into a full FIFO are dropped so the head is never overwritten
  logic [3:0] fifo_wr;
  logic [3:0] fifo_rd;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fifo_wr[i] = push && cur_seq_r == i[1:0] &&
                   cnt_r[i] != adc_seq_pkg::CNT_W'(adc_seq_pkg::FIFO_DEPTH);
      fifo_rd[i] = fifo_pop_i[i] && cnt_r[i] != '0;
    end
  end
  // one averaged entry per step, depth eight
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_r <= '{default: 3'h0};
      rptr_r <= '{default: 3'h0};
      cnt_r  <= '{default: 4'h0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fifo_wr[i]) begin
          wptr_r[i] <= wptr_r[i] + 3'h1;
        end
        if (fifo_rd[i]) begin
          rptr_r[i] <= rptr_r[i] + 3'h1;
        end
        cnt_r[i] <= cnt_r[i] + adc_seq_pkg::CNT_W'(fifo_wr[i]) -
                    adc_seq_pkg::CNT_W'(fifo_rd[i]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (fifo_wr[cur_seq_r]) begin
      mem_r[cur_seq_r][wptr_r[cur_seq_r]] <= avg_val;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_head_o  <= '0;
      fifo_empty_o <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        fifo_empty_o[i]      <= cnt_r[i] == '0;
        fifo_head_o[i].valid <= cnt_r[i] != '0;
        fifo_head_o[i].seq   <= i[1:0];
        fifo_head_o[i].data  <= mem_r[i][rptr_r[i]];
      end
    end
  end

  // ****************************************************************
  // Interrupts and overflow
  // ****************************************************************
  logic [3:0] step_int;
  assign step_int = (push && (cur_step.irq_en || step_last)) ?
                    4'(4'h1 << cur_seq_r) : 4'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_int_r <= 4'h0;
      int_en_r  <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (step_int[i]) begin
          raw_int_r[i] <= 1'b1;
        end else if (int_clear_i[i] || int_enable_i[i]) begin
          raw_int_r[i] <= 1'b0;
        end
        if (int_disable_i[i]) begin
          int_en_r[i] <= 1'b0;
        end else if (int_enable_i[i]) begin
          int_en_r[i] <= 1'b1;
        end
      end
    end
  end

  // overflow when retriggered with unread data, except for always-trigger sequences
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (trig[i] && cnt_r[i] != '0 &&
            seq_cfg_i[i].trig != adc_seq_pkg::TRIG_ALWAYS) begin
          ovf_r[i] <= 1'b1;
        end else if (ovf_clear_i[i]) begin
          ovf_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_status_o <= 4'h0;
      int_o        <= 1'b0;
      overflow_o   <= 4'h0;
      busy_o       <= 4'h0;
    end else begin
      int_status_o <= masked_status_select_i ? (raw_int_r & int_en_r)
                                             : raw_int_r;
      int_o        <= |(raw_int_r & int_en_r);
      overflow_o   <= ovf_r;
      busy_o       <= busy_r;
    end
  end

endmodule

// ### tb/adc_seq_chk.sv
// Checker: port-level assertions for the sample sequencer
`timescale 1ns/100ps
module adc_seq_chk (
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_n_i,
  // Watched ports
  input wire logic                       conv_start_o,
  input wire logic [2:0]                 conv_chan_o,
  input wire logic [3:0]                 int_status_o,
  input wire logic                       int_o,
  input wire logic [3:0]                 overflow_o,
  input wire logic [3:0]                 ovf_clear_i,
  input wire logic [3:0]                 fifo_empty_o,
  input wire adc_seq_pkg::result_s [3:0] fifo_head_o,
  input wire logic [3:0]                 busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Masked never exceeds raw, so a quiet status in either view
  // leaves nothing for the interrupt line to carry
  sequence quiet_seq;
    (int_status_o == 4'h0) [*3];
  endsequence
  sequence start_seq;
    conv_start_o ##1 !conv_start_o;
  endsequence

  start_pulse_a: assert property (conv_start_o |-> start_seq)
    else $error("conversion start held over one cycle");
  chan_range_a: assert property (
    conv_start_o |-> conv_chan_o <= adc_seq_pkg::CHAN_TEMP)
    else $error("conversion channel out of range");
  chan_hold_a: assert property (
    !conv_start_o |-> $stable(conv_chan_o))
    else $error("channel moved between starts");
  start_busy_a: assert property (conv_start_o |-> busy_o != 4'h0)
    else $error("conversion started with no sequence running");
  int_quiet_a: assert property (quiet_seq |-> !int_o)
    else $error("interrupt raised with quiet status");

  for (genvar i = 0; i < 4; i++) begin : g_seq
    head_valid_a: assert property (
      fifo_empty_o[i] == !fifo_head_o[i].valid)
      else $error("empty flag disagrees with head valid");
    ovf_cause_a: assert property ($rose(overflow_o[i]) |->
      !$past(fifo_empty_o[i]) || !$past(fifo_empty_o[i], 2))
      else $error("overflow set with an empty fifo");
    ovf_keep_a: assert property (
      overflow_o[i] && !ovf_clear_i[i] && !$past(ovf_clear_i[i])
      |=> overflow_o[i])
      else $error("overflow dropped without a clear");
  end
endmodule

bind adc_sample_sequencer adc_seq_chk chk (
  .clk_i, .rst_n_i, .conv_start_o, .conv_chan_o, .int_status_o, .int_o,
  .overflow_o, .ovf_clear_i, .fifo_empty_o, .fifo_head_o, .busy_o
);

// ### tb/tb_top.sv
// Testbench: self-checking run of the ADC sample sequencer
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic [1:0] s;
    logic [2:0] ch;
    logic [2:0] f;
    logic [9:0] d;
    logic [9:0] n;
  } row_s;
  // ****************************************************************
  // Signals, design and converter stand-in
  // ****************************************************************
  logic                         clk_i = 1'b0;
  logic                         rst_n_i = 1'b0;
  adc_seq_pkg::seq_cfg_s [3:0]  seq_cfg_i = '0;
  adc_seq_pkg::step_cfg_s [7:0] step_cfg_i [4];
  logic [2:0]                   averaging_factor_i = 3'h0;
  logic [3:0]                   proc_trig_i = 4'h0, int_enable_i = 4'h0;
  logic [3:0]                   int_disable_i = 4'h0, int_clear_i = 4'h0;
  logic [3:0]                   ovf_clear_i = 4'h0, fifo_pop_i = 4'h0;
  logic                         ext_trig_i = 1'b0, timer_trig_i = 1'b0;
  logic                         masked_status_select_i = 1'b0;
  logic                         conv_done_i = 1'b0, conv_start_o, int_o;
  logic [9:0]                   conv_data_i = 10'h0;
  logic [2:0]                   conv_chan_o, cur_ch, ch_log [8];
  logic [3:0]                   int_status_o, overflow_o, fifo_empty_o;
  logic [3:0]                   busy_o;
  adc_seq_pkg::result_s [3:0]   fifo_head_o;
  logic                         alt = 1'b0;
  int                           n_starts = 0, lat = 0, k;
  int                           n_mismatch = 0, check_count = 0;
  logic [2:0] chs [8] = '{3'h5, 3'h1, 3'h5, 3'h6, 3'h0, 3'h2, 3'h2, 3'h4};
  row_s rows [7] = '{'{2'h0, 3'h0, 3'h0, 10'h010, 10'h001},
    '{2'h1, 3'h1, 3'h1, 10'h091, 10'h002},
    '{2'h2, 3'h2, 3'h2, 10'h111, 10'h004},
    '{2'h3, 3'h3, 3'h3, 10'h191, 10'h008},
    '{2'h0, 3'h4, 3'h4, 10'h211, 10'h010},
    '{2'h1, 3'h5, 3'h5, 10'h291, 10'h020},
    '{2'h2, 3'h6, 3'h6, 10'h311, 10'h040}};

  adc_sample_sequencer uut (
    .clk_i, .rst_n_i, .seq_cfg_i, .step_cfg_i, .averaging_factor_i,
    .proc_trig_i, .ext_trig_i, .timer_trig_i, .int_enable_i,
    .int_disable_i, .int_clear_i, .masked_status_select_i, .ovf_clear_i,
    .fifo_pop_i, .conv_start_o, .conv_chan_o, .conv_done_i, .conv_data_i,
    .int_status_o, .int_o, .overflow_o, .fifo_empty_o, .fifo_head_o,
    .busy_o
  );

  always #12.5 clk_i = ~clk_i;

  // Readings alternate base and base+2 so an average lands on base+1;
  // the data bus shows garbage outside the done pulse
  always @(negedge clk_i) begin
    conv_done_i = 1'b0;
    conv_data_i = ~conv_data_i;
    if (lat == 1) begin
      conv_done_i = 1'b1;
      conv_data_i = {cur_ch, 7'h10} + (alt ? 10'h2 : 10'h0);
      alt = ~alt;
    end
    if (lat != 0) lat = lat - 1;
    if (conv_start_o === 1'b1) begin
      cur_ch = conv_chan_o;
      if (n_starts < 8) ch_log[n_starts] = conv_chan_o;
      n_starts++;
      lat = 3;
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
    chk_val({6'h0, got}, {6'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic [3:0] sig, input logic [3:0] m);
    sig = m;
    tick(1);
    sig = 4'h0;
    tick(1);
  endtask
  task automatic wait_idle(input int s);
    int w;
    w = 0;
    tick(4);
    while ((fifo_empty_o[s] !== 1'b0 || busy_o !== 4'h0) && w < 3000) begin
      tick(1);
      w++;
    end
    if (w == 3000) begin
      n_mismatch++;
      wrap_up;
    end
  endtask
  task automatic pop(input int s);
    fifo_pop_i[s] = 1'b1;
    tick(1);
    fifo_pop_i = 4'h0;
    tick(2);
  endtask
  task automatic cfg(input int s, input adc_seq_pkg::trig_src_e t,
                     input logic [1:0] p, input logic [3:0] n,
                     input logic [2:0] ch);
    seq_cfg_i[s] = '{1'b1, t, p, n};
    step_cfg_i[s][0].chan = ch;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int s = 0; s < 4; s++) step_cfg_i[s] = '0;
    tick(16);
    rst_n_i = 1'b1;
    tick(1);
    chk_bits(fifo_empty_o, 4'hf);
    chk_bits(overflow_o | int_status_o | busy_o, 4'h0);
    foreach (rows[r]) begin
      seq_cfg_i = '0;
      cfg(rows[r].s, adc_seq_pkg::TRIG_PROCESSOR, 2'h0, 4'h1, rows[r].ch);
      averaging_factor_i = rows[r].f;
      n_starts = 0;
      alt = 1'b0;
      pulse(proc_trig_i, 4'h1 << rows[r].s);
      wait_idle(rows[r].s);
      chk_val(fifo_head_o[rows[r].s].data, rows[r].d);
      chk_val(10'(n_starts), rows[r].n);
      chk_bits(4'(fifo_head_o[rows[r].s].seq), 4'(rows[r].s));
      pop(rows[r].s);
      $display("row %0d done", r);
    end
    averaging_factor_i = 3'h0;
    pulse(int_clear_i, 4'hf);
    seq_cfg_i = '0;
    cfg(0, adc_seq_pkg::TRIG_PROCESSOR, 2'h0, 4'h8, 3'h5);
    for (int j = 0; j < 8; j++) step_cfg_i[0][j].chan = chs[j];
    n_starts = 0;
    alt = 1'b0;
    pulse(proc_trig_i, 4'h1);
    wait_idle(0);
    for (int j = 0; j < 8; j++) begin
      chk_bits(4'(ch_log[j]), 4'(chs[j]));
      chk_val(fifo_head_o[0].data, {chs[j], 7'h10} + 10'(2 * j[0]));
      pop(0);
    end
    $display("eight step test done");
    seq_cfg_i = '0;
    cfg(0, adc_seq_pkg::TRIG_PROCESSOR, 2'h3, 4'h1, 3'h1);
    cfg(3, adc_seq_pkg::TRIG_PROCESSOR, 2'h0, 4'h1, 3'h4);
    n_starts = 0;
    pulse(proc_trig_i, 4'h9);
    wait_idle(0);
    chk_bits(4'(ch_log[0]), 4'h4);
    chk_bits(fifo_empty_o, 4'h6);
    pulse(proc_trig_i, 4'h8);
    wait_idle(3);
    chk_bits(overflow_o, 4'h8);
    pulse(ovf_clear_i, 4'h8);
    chk_bits(overflow_o, 4'h0);
    $display("priority and overflow test done");
    chk_bits(int_status_o, 4'h9);
    pulse(int_clear_i, 4'h8);
    chk_bits(int_status_o, 4'h1);
    pulse(int_enable_i, 4'h1);
    chk_bits({int_o, int_status_o[2:0]}, 4'h0);
    pop(3);
    pop(3);
    pop(0);
    pulse(proc_trig_i, 4'h1);
    wait_idle(0);
    masked_status_select_i = 1'b1;
    tick(2);
    chk_bits({int_o, int_status_o[2:0]}, 4'h9);
    pulse(int_disable_i, 4'h1);
    chk_bits({int_o, int_status_o[2:0]}, 4'h0);
    masked_status_select_i = 1'b0;
    tick(2);
    chk_bits(int_status_o, 4'h1);
    pop(0);
    $display("interrupt test done");
    seq_cfg_i = '0;
    cfg(1, adc_seq_pkg::TRIG_TIMER, 2'h0, 4'h1, 3'h2);
    cfg(2, adc_seq_pkg::TRIG_EXTERNAL, 2'h1, 4'h1, 3'h3);
    pulse(proc_trig_i, 4'h6);
    tick(20);
    chk_bits(fifo_empty_o, 4'hf);
    timer_trig_i = 1'b1;
    tick(1);
    timer_trig_i = 1'b0;
    wait_idle(1);
    ext_trig_i = 1'b1;
    tick(1);
    ext_trig_i = 1'b0;
    wait_idle(2);
    chk_bits(fifo_empty_o, 4'h9);
    pop(1);
    pop(2);
    $display("trigger source test done");
    cfg(2, adc_seq_pkg::TRIG_ALWAYS, 2'h0, 4'h1, 3'h6);
    n_starts = 0;
    k = 0;
    while (n_starts < 12 && k < 2000) begin
      tick(1);
      k++;
    end
    chk_bits({3'h0, n_starts >= 12}, 4'h1);
    chk_bits(overflow_o, 4'h0);
    seq_cfg_i = '0;
    $display("continuous trigger test done");
    wrap_up;
  end
endmodule
